// ---- ncr_pkg.sv ----
// Package with command register layout, encodings and host register map.
package ncr_pkg;
    localparam logic [3:0] NCR_CMD_OFFSET = 4'h0;
    localparam int NCR_HALT_POS = 0;
    localparam int NCR_ACT_POS = 1;
    localparam int NCR_SEND_POS = 2;
    localparam int NCR_RCMD_LO = 3;
    localparam int NCR_RCMD_HI = 5;
    localparam int NCR_PAGE_LO = 6;
    localparam int NCR_PAGE_HI = 7;
    localparam logic [7:0] NCR_CMD_RESET = 8'h01;
    localparam logic [7:0] NCR_ZERO8 = 8'h00;
    localparam logic [2:0] NCR_RCMD_NONE = 3'h0;
    localparam logic [2:0] NCR_RCMD_READ = 3'h1;
    localparam logic [2:0] NCR_RCMD_WRITE = 3'h2;
    localparam logic [2:0] NCR_RCMD_SEND = 3'h3;
    localparam logic [2:0] NCR_RCMD_ABORT = 3'h4;
    localparam logic [1:0] NCR_PAGE0 = 2'h0;
    // Host register map of its own command port.
    localparam logic [1:0] NCR_HOST_CMD = 2'h0;
    localparam logic [1:0] NCR_HOST_STAT = 2'h1;
    localparam logic [1:0] NCR_HOST_DATA = 2'h2;
    localparam logic [1:0] NCR_HOST_ADDR = 2'h3;
endpackage : ncr_pkg

// ---- ncr_if.sv ----
// Interface joining the host end and the command register end.
interface ncr_if;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    modport dev (input reg_addr, input reg_wdata, input reg_wr, input reg_rd, output reg_rdata);
    modport host (output reg_addr, output reg_wdata, output reg_wr, output reg_rd,
        input reg_rdata);
endinterface : ncr_if

// ---- ncr_device.sv ----
// Command register logic of the network interface core.
// Functional notes
// - Halt bit takes core offline as soft reset.
// - Frames in progress finish before reset state.
// - Host clears halt and sets activate to leave.
// - Reset indication flag set when reset effective.
// - Power-up: halt reads one, activate zero.
// - Halt after start: both bits read set.
// - Activate bit starts core after any reset.
// - Send bit starts frame, self-clears when done.
// - Host programs count and page before send.
// - Writing zero to send bit does nothing.
// - Host rewrites remote field with send bit.
// - Reissued remote command without count ends immediately.
// - Host starts remote DMA with send zero.
// - Host never overlaps remote read and write.
// - Page, abort and halt writable any time.
// - Remote field top bit aborts remote DMA.
// - Host clears remote count after abort.
// - Abort keeps current remote address unchanged.
// - Remote field encodes read, write, send, abort.
// - Page bits select register page.
//
// Design decision made here: the strobed register port.
module ncr_device
    import ncr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    ncr_if.dev bus,
    input wire logic [7:0] page_rdata,
    input wire logic rx_busy,
    input wire logic tx_done,
    input wire logic tx_abort,
    input wire logic rdma_done,
    input wire logic rcount_reloaded,
    output logic core_active,
    output logic reset_flag,
    output logic tx_start,
    output logic [2:0] rdma_cmd,
    output logic rdma_active,
    output logic rdma_start,
    output logic rdma_abort,
    output logic [1:0] page_sel,
    output logic [3:0] page_addr,
    output logic page_wr,
    output logic page_rd
);
    // Stored command bits, their readback view and the write decode.
    logic halt_bit;
    logic act_bit;
    logic send_bit;
    logic [7:0] rdata;
    logic [7:0] cmd_view;
    logic cmd_hit;
    logic cmd_wr;
    logic [2:0] wr_rcmd;
    logic wr_abort;
    logic wr_send;
    logic running;
    logic reissue;
    logic halting;

    // Decode of a host write aimed at the command register.
    // Any other offset is left to the page registers outside this block.
    assign cmd_hit = (bus.reg_addr == NCR_CMD_OFFSET);
    assign cmd_wr = bus.reg_wr && cmd_hit;
    assign wr_rcmd = bus.reg_wdata[NCR_RCMD_HI:NCR_RCMD_LO];
    assign wr_abort = wr_rcmd[NCR_RCMD_HI - NCR_RCMD_LO];
    assign wr_send = bus.reg_wdata[NCR_SEND_POS];

    // The core runs while activated and no halt is pending.
    assign running = act_bit && !halt_bit;

    // A halt only sets the reset indication when no frame is moving.
    // Until then the reset indication stays low, so software can poll it.
    assign halting = halt_bit && !rx_busy && !send_bit;

    // The same remote command written again together with a send, with no new
    // count loaded, must end the running remote transfer at once.
    assign reissue = rdma_active && wr_send && (wr_rcmd == rdma_cmd) && !rcount_reloaded;

    // Halt and activate bits; a halt keeps activate set as it was, so that a
    // core halted from start mode reads back with both bits high.
    // Activate only drops when a write has neither halt nor activate set.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            halt_bit <= NCR_CMD_RESET[NCR_HALT_POS];
            act_bit <= NCR_CMD_RESET[NCR_ACT_POS];
        end else if (cmd_wr) begin
            halt_bit <= bus.reg_wdata[NCR_HALT_POS];
            if (bus.reg_wdata[NCR_ACT_POS]) begin
                act_bit <= 1'b1;
            end else if (!bus.reg_wdata[NCR_HALT_POS]) begin
                act_bit <= 1'b0;
            end
        end
    end

    // Core state and reset indication. The core goes offline at once on a
    // halt, so no new frame is started; the indication waits until the last
    // frame in flight has finished.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_active <= 1'b0;
            reset_flag <= 1'b1;
        end else begin
            core_active <= running;
            if (halting) begin
                reset_flag <= 1'b1;
            end else if (running) begin
                reset_flag <= 1'b0;
            end
        end
    end

    // Send bit: only a written one sets it, and only on a running core that is
    // not already sending; completion or abort of the frame clears it.
    // A completion seen while no frame is pending is simply ignored.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            send_bit <= 1'b0;
            tx_start <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            if (cmd_wr && wr_send && !send_bit && running) begin
                send_bit <= 1'b1;
                tx_start <= 1'b1;
            end else if (tx_done || tx_abort) begin
                send_bit <= 1'b0;
            end
        end
    end

    // Remote command field with its start and abort pulses. A top bit aborts
    // at any time; other codes start a transfer when none is running. Code
    // zero is not allowed and leaves everything as it was. A completion that
    // meets a plain rewrite of the running command is never lost.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdma_cmd <= NCR_RCMD_ABORT;
            rdma_active <= 1'b0;
            rdma_start <= 1'b0;
            rdma_abort <= 1'b0;
        end else begin
            rdma_start <= 1'b0;
            rdma_abort <= 1'b0;
            if (cmd_wr && wr_abort) begin
                rdma_cmd <= wr_rcmd;
                rdma_active <= 1'b0;
                rdma_abort <= rdma_active;
            end else if (cmd_wr && wr_rcmd != NCR_RCMD_NONE) begin
                rdma_cmd <= wr_rcmd;
                if (reissue) begin
                    rdma_active <= 1'b0;
                end else if (!rdma_active) begin
                    rdma_active <= 1'b1;
                    rdma_start <= 1'b1;
                end else if (rdma_done) begin
                    rdma_active <= 1'b0;
                end
            end else if (rdma_done) begin
                rdma_active <= 1'b0;
            end
        end
    end

    // Page select bits, writable at any time, even while a frame or a remote
    // transfer is in progress.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            page_sel <= NCR_PAGE0;
        end else if (cmd_wr) begin
            page_sel <= bus.reg_wdata[NCR_PAGE_HI:NCR_PAGE_LO];
        end
    end

    // Other offsets pass through to the selected page; the page registers
    // decode the page select bits themselves.
    assign page_addr = bus.reg_addr;
    assign page_wr = bus.reg_wr && !cmd_hit;
    assign page_rd = bus.reg_rd && !cmd_hit;

    // Command register view, assembled field by field for readback.
    // Keeping it apart from the read flop keeps the field layout in one place.
    always_comb begin
        cmd_view = NCR_ZERO8;
        cmd_view[NCR_HALT_POS] = halt_bit;
        cmd_view[NCR_ACT_POS] = act_bit;
        cmd_view[NCR_SEND_POS] = send_bit;
        cmd_view[NCR_RCMD_HI:NCR_RCMD_LO] = rdma_cmd;
        cmd_view[NCR_PAGE_HI:NCR_PAGE_LO] = page_sel;
    end

    // Read data one cycle after the read strobe, held until the next read.
    // The command offset is answered here; every other one by the page.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= NCR_ZERO8;
        end else if (bus.reg_rd) begin
            if (cmd_hit) begin
                rdata <= cmd_view;
            end else begin
                rdata <= page_rdata;
            end
        end
    end
    assign bus.reg_rdata = rdata;
endmodule : ncr_device

// ---- ncr_host.sv ----
// Host end that issues register accesses from a software port.
module ncr_host
    import ncr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    ncr_if.host bus,
    input wire logic [1:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata
);
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rd_pend;
    logic [7:0] last;

    // Software sets address and data, then fires a write or read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr <= NCR_CMD_OFFSET;
            wdata <= NCR_ZERO8;
            wr <= 1'b0;
            rd <= 1'b0;
        end else begin
            wr <= sw_wr && sw_addr == NCR_HOST_CMD;
            rd <= sw_wr && sw_addr == NCR_HOST_STAT;
            if (sw_wr && sw_addr == NCR_HOST_DATA) begin
                wdata <= sw_wdata;
            end
            if (sw_wr && sw_addr == NCR_HOST_ADDR) begin
                addr <= sw_wdata[3:0];
            end
        end
    end

    // Capture device read data and answer software reads.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_pend <= 1'b0;
            last <= NCR_ZERO8;
            sw_rdata <= NCR_ZERO8;
        end else begin
            rd_pend <= rd;
            if (rd_pend) begin
                last <= bus.reg_rdata;
            end
            if (sw_rd) begin
                sw_rdata <= (sw_addr == NCR_HOST_DATA) ? last : {4'h0, addr};
            end
        end
    end
    assign bus.reg_addr = addr;
    assign bus.reg_wdata = wdata;
    assign bus.reg_wr = wr;
    assign bus.reg_rd = rd;
endmodule : ncr_host

// ---- ncr_monitor.sv ----
// Checker of command register behaviour seen across the interface.
module ncr_monitor
    import ncr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_busy,
    input wire logic core_active,
    input wire logic reset_flag,
    input wire logic tx_start,
    input wire logic rdma_start,
    input wire logic rdma_abort,
    input wire logic [1:0] page_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Command writes that halt or start the core.
    sequence halt_wr;
        reg_wr && reg_addr == NCR_CMD_OFFSET && reg_wdata[NCR_HALT_POS] && !rx_busy;
    endsequence
    sequence start_wr;
        reg_wr && reg_addr == NCR_CMD_OFFSET && reg_wdata[1:0] == 2'h2;
    endsequence
    chk_halt_offline: assert property (halt_wr |-> ##[1:3] !core_active)
        else $error("core active after halt");
    chk_halt_flag: assert property (halt_wr ##1 (!rx_busy) [*3] |-> reset_flag)
        else $error("reset flag missing after halt");
    chk_busy_flag: assert property (rx_busy && $past(rx_busy) |-> !$rose(reset_flag))
        else $error("reset flag rose during reception");
    chk_power_up: assert property ($fell(rst) |-> reset_flag && !core_active)
        else $error("wrong state after reset");
    chk_start_core: assert property (start_wr |-> ##[1:3] core_active)
        else $error("core not started");
    chk_send_cause: assert property (tx_start |-> $past(reg_wr) && $past(reg_wdata[2]))
        else $error("send pulse without send write");
    chk_abort_cause: assert property (rdma_abort |-> $past(reg_wr) && $past(reg_wdata[5]))
        else $error("abort pulse without abort write");
    chk_rstart_code: assert property (rdma_start |-> !$past(reg_wdata[5]) && $past(reg_wr))
        else $error("remote start with bad code");
    chk_page_write: assert property (reg_wr && reg_addr == NCR_CMD_OFFSET
        |=> page_sel == $past(reg_wdata[7:6]))
        else $error("page select not taken");
    chk_page_read: assert property (reg_rd && reg_addr == NCR_CMD_OFFSET
        |=> reg_rdata[7:6] == $past(page_sel))
        else $error("page bits not read back");
endmodule : ncr_monitor

// ---- nic_command_register_bench.sv ----
// Testbench driving the host software port against the command register end.
module nic_command_register_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst = 1, rx_busy = 0, tx_done = 0, tx_abort = 0, sw_wr = 0, sw_rd = 0;
    logic rcount_reloaded = 0, page_wr, page_rd;
    logic [3:0] page_addr;
    logic [1:0] sw_addr = 2'h0, page_sel;
    logic [7:0] sw_wdata = 8'h00, sw_rdata, rd_val;
    logic core_active, reset_flag, tx_start, rdma_active, rdma_start, rdma_abort;
    logic [2:0] rdma_cmd;
    int n_errors = 0, checks_done = 0, n_tx = 0, n_ab = 0;
    int n_rs = 0, n_pw = 0, n_pr = 0;
    // Clock of 50 ns period.
    initial forever #25 ref_clk = ~ref_clk;
    ncr_if i_ncr_if ();
    ncr_device i_ncr_device (.ref_clk(ref_clk), .rst(rst), .bus(i_ncr_if), .page_rdata(8'hA5),
        .rx_busy(rx_busy), .tx_done(tx_done), .tx_abort(tx_abort), .rdma_done(1'b0),
        .rcount_reloaded(rcount_reloaded), .core_active(core_active), .reset_flag(reset_flag),
        .tx_start(tx_start), .rdma_cmd(rdma_cmd), .rdma_active(rdma_active),
        .rdma_start(rdma_start), .rdma_abort(rdma_abort), .page_sel(page_sel),
        .page_addr(page_addr), .page_wr(page_wr), .page_rd(page_rd));
    ncr_host i_ncr_host (.ref_clk(ref_clk), .rst(rst), .bus(i_ncr_if), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    ncr_monitor i_ncr_monitor (.ref_clk(ref_clk), .rst(rst), .reg_addr(i_ncr_if.reg_addr),
        .reg_wdata(i_ncr_if.reg_wdata), .reg_wr(i_ncr_if.reg_wr), .reg_rd(i_ncr_if.reg_rd),
        .reg_rdata(i_ncr_if.reg_rdata), .rx_busy(rx_busy), .core_active(core_active),
        .reset_flag(reset_flag), .tx_start(tx_start), .rdma_start(rdma_start),
        .rdma_abort(rdma_abort), .page_sel(page_sel));
    // Counts of the one-cycle command pulses and page register strobes.
    always @(posedge ref_clk) begin
        n_tx <= n_tx + int'(tx_start);
        n_ab <= n_ab + int'(rdma_abort);
        n_rs <= n_rs + int'(rdma_start);
        n_pw <= n_pw + int'(page_wr && page_addr == 4'h4);
        n_pr <= n_pr + int'(page_rd && page_addr == 4'h5);
    end
    task automatic put(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : put
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        put(2'h3, {4'h0, a});
        put(2'h2, d);
        put(2'h0, 8'h00);
        repeat (4) @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        put(2'h3, {4'h0, a});
        put(2'h1, 8'h00);
        repeat (4) @(posedge ref_clk);
        sw_addr <= 2'h2;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        @(negedge ref_clk);
        v = sw_rdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : cmp1
    task automatic rdc(input logic [7:0] exp);
        rd(4'h0, rd_val);
        cmp8(rd_val, exp);
    endtask : rdc
    task automatic end_tx();
        tx_done <= 1'b1;
        @(posedge ref_clk);
        tx_done <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : end_tx
    task automatic wrap_up();
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // Main sequence of command scenarios.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(8'h21);
        cmp1(reset_flag, 1'b1);
        wr(4'h0, 8'h22);
        cmp1(core_active, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wr(4'h4, 8'h40);
            wr(4'h0, 8'h26);
            wr(4'h0, 8'h22);
            rdc(8'h26);
            tx_done <= (k == 0);
            tx_abort <= (k == 1);
            @(posedge ref_clk);
            tx_done <= 1'b0;
            tx_abort <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rdc(8'h22);
        end
        cmp8(8'(n_tx), 8'h02);
        cmp8(8'(n_pw), 8'h02);
        for (int c = 1; c < 4; c++) begin
            wr(4'h0, {2'h0, 3'(c), 3'h2});
            cmp8({5'h0, rdma_cmd}, 8'(c));
            wr(4'h0, 8'h22);
            cmp1(rdma_active, 1'b0);
        end
        cmp8(8'(n_ab), 8'h03);
        wr(4'h0, 8'h02);
        cmp8({5'h0, rdma_cmd}, 8'h04);
        wr(4'h0, 8'h0A);
        wr(4'h0, 8'h0E);
        cmp1(rdma_active, 1'b0);
        end_tx();
        rcount_reloaded <= 1'b1;
        wr(4'h0, 8'h0A);
        wr(4'h0, 8'h0E);
        cmp1(rdma_active, 1'b1);
        end_tx();
        wr(4'h0, 8'h22);
        rcount_reloaded <= 1'b0;
        cmp8(8'(n_ab), 8'h04);
        cmp8(8'(n_rs), 8'h05);
        cmp8(8'(n_tx), 8'h04);
        wr(4'h0, 8'h62);
        rdc(8'h62);
        rd(4'h5, rd_val);
        cmp8(rd_val, 8'hA5);
        cmp8(8'(n_pr), 8'h01);
        rx_busy <= 1'b1;
        wr(4'h0, 8'h23);
        rdc(8'h23);
        cmp1(reset_flag, 1'b0);
        rx_busy <= 1'b0;
        for (int i = 0; i < 20 && reset_flag !== 1'b1; i++) @(posedge ref_clk);
        cmp1(reset_flag, 1'b1);
        cmp1(core_active, 1'b0);
        wr(4'h0, 8'h22);
        cmp1(core_active, 1'b1);
        wr(4'h0, 8'h21);
        cmp1(core_active, 1'b0);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        rdc(8'h21);
        cmp1(core_active, 1'b0);
        wrap_up();
    end
endmodule : nic_command_register_bench
